// ===== host_strobe_map.svh
// host_strobe_map.svh: constants for the host strobe/select decoder
// assumes inclusion by bare name from the decoder module
`ifndef HOST_STROBE_MAP_SVH
`define HOST_STROBE_MAP_SVH
// host bus type encodings on the bus-select input
`define BUS_SEL_GENERIC 2'h0
`define BUS_SEL_PROC_A 2'h1
`define BUS_SEL_PROC_B 2'h2
// default host data width
`define HOST_DATA_W 8
// reset value of the captured write data
`define WDATA_RESET 8'h00
`endif

// ===== host_strobe_pkg.sv
// host_strobe_pkg: types shared by the host strobe decoder files
// assumes host_strobe_map.svh is on the include path
package host_strobe_pkg;
    typedef enum logic [1:0] {
        BUS_GENERIC = 2'b00,
        BUS_PROC_A = 2'b01,
        BUS_PROC_B = 2'b10,
        BUS_NONE = 2'b11
    } bus_type_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_STROBE = 2'b01,
        ST_DIR = 2'b10
    } cyc_state_t;
endpackage

// ===== pin_sync_if.sv
// pin_sync_if: synchronised host control levels between sync and decoder
// assumes one clock domain on both sides
`timescale 1ns/1ps
`default_nettype none
interface pin_sync_if;
    logic cs_n;
    logic wr_ctl;
    modport src (output cs_n, output wr_ctl);
    modport dst (input cs_n, input wr_ctl);
endinterface
`default_nettype wire

// ===== host_pin_sync.sv
// host_pin_sync: three-stage synchronisers for chip select and write control
// assumes pins are asynchronous to i_ref_clk
`timescale 1ns/1ps
`default_nettype none
module host_pin_sync (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset,
    // raw pins
    input wire logic i_cs_n,
    input wire logic i_wr_ctl,
    // filtered levels
    pin_sync_if.src o_sync
);
    logic [2:0] cs_q, cs_d;
    logic [2:0] wr_q, wr_d;
    logic cs_lvl_q, cs_lvl_d;
    logic wr_lvl_q, wr_lvl_d;
    // a level changes only once stages two and three agree
    always_comb begin
        cs_d = {cs_q[1:0], i_cs_n};
        wr_d = {wr_q[1:0], i_wr_ctl};
        cs_lvl_d = (cs_q[2] == cs_q[1]) ? cs_q[2] : cs_lvl_q;
        wr_lvl_d = (wr_q[2] == wr_q[1]) ? wr_q[2] : wr_lvl_q;
    end
    // idle levels at reset: deselected, strobe high
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            cs_q <= 3'h7;
            wr_q <= 3'h7;
            cs_lvl_q <= 1'b1;
            wr_lvl_q <= 1'b1;
        end else begin
            cs_q <= cs_d;
            wr_q <= wr_d;
            cs_lvl_q <= cs_lvl_d;
            wr_lvl_q <= wr_lvl_d;
        end
    end
    assign o_sync.cs_n = cs_lvl_q;
    assign o_sync.wr_ctl = wr_lvl_q;
endmodule
`default_nettype wire

// ===== host_strobe_select_decode.sv
// host_strobe_select_decode: decodes the shared write-control pin and chip select
// assumes host pins are asynchronous; data bus is held stable around the strobe
`timescale 1ns/1ps
`default_nettype none
`include "host_strobe_map.svh"

// Contract
// - generic mode: low write pin marks write
// - generic mode: capture data on strobe rise
// - proc mode A: high reads, low writes
// - proc mode B: high reads, low writes
// - respond only while chip select low
module host_strobe_select_decode
    import host_strobe_pkg::*;
#(
    parameter int DATA_W = `HOST_DATA_W
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset,
    // configuration
    input wire logic [1:0] i_bus_sel,
    // host pins
    input wire logic i_cs_n,
    input wire logic i_wr_ctl,
    input wire logic [DATA_W-1:0] i_host_data,
    // decoded cycle
    output logic o_selected,
    output logic o_write_active,
    output logic o_read_active,
    output logic o_wdata_valid,
    output logic [DATA_W-1:0] o_wdata
);
    // elaboration check: the reset constant and the capture register are
    // sized from DATA_W; words wider than 32 bits were never a goal
    if (DATA_W < 1 || DATA_W > 32) begin : g_bad_width
        $error("DATA_W must lie between 1 and 32");
    end

    // synchronised chip select and write-control levels
    pin_sync_if sync_if ();

    // data alignment pipe
    logic [DATA_W-1:0] d1_q;
    logic [DATA_W-1:0] d1_d;
    logic [DATA_W-1:0] d2_q;
    logic [DATA_W-1:0] d2_d;
    logic [DATA_W-1:0] d3_q;
    logic [DATA_W-1:0] d3_d;
    // bus type latched while deselected, and the cycle state
    bus_type_t bus_q;
    bus_type_t bus_d;
    cyc_state_t st_q;
    cyc_state_t st_d;
    // filtered write-control level one clock back, for the rise detector
    logic wr_prev_q;
    logic wr_prev_d;
    // captured word and its one-cycle flag
    logic [DATA_W-1:0] wdata_q;
    logic [DATA_W-1:0] wdata_d;
    logic valid_q;
    logic valid_d;
    // direction levels
    logic wr_q;
    logic wr_d;
    logic rd_q;
    logic rd_d;
    // decode shared by the capture and direction groups
    logic sel_now;
    logic strobe_rise;

    // the synchroniser owns the select and strobe pins; logic below sees their filtered levels, while the data pins feed the alignment pipe
    host_pin_sync u_sync (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_cs_n(i_cs_n),
        .i_wr_ctl(i_wr_ctl),
        .o_sync(sync_if)
    );

    // bus-select code to bus type; the spare code maps to a mode that
    // ignores the pins rather than to a guess
    function automatic bus_type_t decode_bus(input logic [1:0] sel);
        if (sel == `BUS_SEL_GENERIC) begin
            decode_bus = BUS_GENERIC;
        end else if (sel == `BUS_SEL_PROC_A) begin
            decode_bus = BUS_PROC_A;
        end else if (sel == `BUS_SEL_PROC_B) begin
            decode_bus = BUS_PROC_B;
        end else begin
            decode_bus = BUS_NONE;
        end
    endfunction

    // both processor-style buses use the shared pin as a direction level
    function automatic logic is_proc(input bus_type_t bus);
        is_proc = (bus == BUS_PROC_A) || (bus == BUS_PROC_B);
    endfunction

    // selected means the filtered chip select is low
    assign sel_now = !sync_if.cs_n;
    // a rise of the filtered strobe while selected in generic mode; one
    // clock of history is enough because the filter removes bounces
    assign strobe_rise = sel_now && (bus_q == BUS_GENERIC)
        && !wr_prev_q && sync_if.wr_ctl;

    // data alignment: three stages, one fewer than the strobe path with its level register, so
    // the word taken at the filtered rise is the one that stood at the pin
    // at the second clock after the rise; the host must hold it there for a few clocks
    always_comb begin
        d1_d = i_host_data;
        d2_d = d1_q;
        d3_d = d2_q;
    end

    // data pipe registers
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            d1_q <= '0;
            d2_q <= '0;
            d3_q <= '0;
        end else begin
            d1_q <= d1_d;
            d2_q <= d2_d;
            d3_q <= d3_d;
        end
    end

    // bus type and cycle state; the bus type is taken only while
    // deselected, so a mode change can never tear a running cycle
    // limitation: a strobe rise in the same clock as the filtered select
    // going high counts as deselected and is dropped
    always_comb begin
        bus_d = bus_q;
        st_d = st_q;
        wr_prev_d = sync_if.wr_ctl;
        if (!sel_now) begin
            bus_d = decode_bus(i_bus_sel);
            st_d = ST_IDLE;
            // forget the strobe history so that a rise seen while
            // deselected cannot capture on the next select
            wr_prev_d = 1'b1;
        end else begin
            case (bus_q)
                BUS_GENERIC: begin
                    st_d = ST_STROBE;
                end
                BUS_PROC_A, BUS_PROC_B: begin
                    st_d = ST_DIR;
                end
                default: begin
                    st_d = ST_IDLE; // spare code: pins ignored
                end
            endcase
        end
    end

    // bus type and cycle state registers
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            bus_q <= BUS_GENERIC;
            st_q <= ST_IDLE;
            wr_prev_q <= 1'b1;
        end else begin
            bus_q <= bus_d;
            st_q <= st_d;
            wr_prev_q <= wr_prev_d;
        end
    end

    // capture: the word is taken on the filtered rise and held until the
    // next one; the flag stands for exactly one clock
    always_comb begin
        wdata_d = wdata_q;
        valid_d = 1'b0;
        if (strobe_rise) begin
            wdata_d = d3_q;
            valid_d = 1'b1;
        end
    end

    // capture registers; deselected cycles leave the word untouched
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            wdata_q <= DATA_W'(`WDATA_RESET);
            valid_q <= 1'b0;
        end else begin
            wdata_q <= wdata_d;
            valid_q <= valid_d;
        end
    end

    // direction levels; both stay low outside a selected cycle, and the
    // pin can only say one thing, so they are never high together
    always_comb begin
        wr_d = 1'b0;
        rd_d = 1'b0;
        if (sel_now) begin
            if (bus_q == BUS_GENERIC) begin
                wr_d = ~sync_if.wr_ctl; // low strobe marks a write
            end else if (is_proc(bus_q)) begin
                rd_d = sync_if.wr_ctl; // high reads
                wr_d = ~sync_if.wr_ctl; // low writes
            end
        end
    end

    // direction registers
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
        end
    end

    // outputs straight from flip-flops; selected is a compare on the state
    // register, which a bus type of the spare code keeps at idle
    assign o_selected = (st_q != ST_IDLE);
    assign o_write_active = wr_q;
    assign o_read_active = rd_q;
    assign o_wdata_valid = valid_q;
    assign o_wdata = wdata_q;
endmodule
`default_nettype wire

// ===== host_strobe_select_decode_monitor.sv
// checks on the decoder's ports
// assumes binding to each decoder instance
`timescale 1ns/1ps
`default_nettype none
module host_strobe_select_decode_monitor #(parameter int DATA_W = 8) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset,
    // inputs and outputs watched
    input wire logic [1:0] i_bus_sel,
    input wire logic i_cs_n,
    input wire logic i_wr_ctl,
    input wire logic [DATA_W-1:0] i_host_data,
    input wire logic o_selected,
    input wire logic o_write_active,
    input wire logic o_read_active,
    input wire logic o_wdata_valid,
    input wire logic [DATA_W-1:0] o_wdata
);
    // eight quiet cycles leave room for the three-stage synchroniser
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    a_valid_pulse: assert property (o_wdata_valid |=> !o_wdata_valid)
        else $error("valid held");
    a_data_moves: assert property ($changed(o_wdata) |-> o_wdata_valid)
        else $error("data moved");
    a_desel_idle: assert property (
        i_cs_n [*8] |-> !o_selected && !o_write_active && !o_wdata_valid)
        else $error("active while off");
    a_gen_write: assert property (
        (!i_cs_n && !i_wr_ctl && i_bus_sel == 2'h0) [*8] |-> o_write_active)
        else $error("no write");
    a_proc_read: assert property (
        (!i_cs_n && i_wr_ctl && ^i_bus_sel) [*8] |-> o_read_active)
        else $error("no read");
    a_proc_write: assert property (
        (!i_cs_n && !i_wr_ctl && ^i_bus_sel) [*8] |-> o_write_active && !o_read_active)
        else $error("no proc write");
    a_one_dir: assert property (o_write_active |-> !o_read_active)
        else $error("both ways");
endmodule
bind host_strobe_select_decode host_strobe_select_decode_monitor #(.DATA_W(DATA_W)) mon (
    .i_ref_clk, .i_reset, .i_bus_sel, .i_cs_n, .i_wr_ctl, .i_host_data, .o_selected,
    .o_write_active, .o_read_active, .o_wdata_valid, .o_wdata);
`default_nettype wire

// ===== host_cpu_model.sv
// host processor behind an address decoder
// assumes tasks are called between clock edges
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
    // clock
    input wire logic i_ref_clk,
    // host pins
    output logic o_cs_n,
    output logic o_wr_ctl,
    output logic [7:0] o_data
);
    // idle: deselected, strobe high
    initial begin
        o_cs_n = 1'b1;
        o_wr_ctl = 1'b1;
        o_data = 8'h00;
    end
    // decoder selects first, then low marks a write
    task automatic start(input logic en, input logic w, input logic [7:0] d);
        @(negedge i_ref_clk) o_cs_n = !en;
        @(negedge i_ref_clk) o_wr_ctl = !w;
        o_data = d;
    endtask
    // strobe rises with data steady; a released bus must not keep its value
    task automatic stop();
        @(negedge i_ref_clk) o_wr_ctl = 1'b1;
        repeat (6) @(negedge i_ref_clk);
        o_cs_n = 1'b1;
        o_data = ~o_data;
    endtask
endmodule
`default_nettype wire

// ===== host_strobe_select_decode_tb_top.sv
// directed host cycles in each bus mode
// assumes the host model drives the pins
`timescale 1ns/1ps
`default_nettype none
module host_strobe_select_decode_tb_top;
    logic i_ref_clk = 0;
    logic i_reset = 1;
    logic [1:0] i_bus_sel = 2'h0;
    wire logic cs, wr, o_selected, o_write_active, o_read_active, o_wdata_valid;
    wire logic [7:0] dq, o_wdata;
    int miscompares = 0, check_count = 0, pulses = 0, cycles = 0;
    // clock
    initial begin
        forever #2.5 i_ref_clk = ~i_ref_clk;
    end
    host_cpu_model cpu (.i_ref_clk, .o_cs_n(cs), .o_wr_ctl(wr), .o_data(dq));
    host_strobe_select_decode dut (.i_ref_clk, .i_reset, .i_bus_sel, .i_cs_n(cs),
        .i_wr_ctl(wr), .i_host_data(dq), .o_selected, .o_write_active, .o_read_active,
        .o_wdata_valid, .o_wdata);
    task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // pulse counter, sampled mid-cycle away from the launching edge; hang guard
    always @(negedge i_ref_clk) begin
        cycles++;
        if (o_wdata_valid === 1'b1) pulses++;
        if (cycles == 1000) begin
            miscompares++;
            conclude();
        end
    end
    // one host cycle: mode, select, write, data, expected held word
    task automatic run(input logic [1:0] m, input logic en, w, input logic [7:0] d, e);
        int p;
        @(negedge i_ref_clk) i_bus_sel = m;
        repeat (4) @(negedge i_ref_clk);
        p = pulses;
        cpu.start(en, w, d);
        repeat (8) @(negedge i_ref_clk);
        check("sel", {7'h00, o_selected}, {7'h00, en & (m != 2'h3)});
        check("wr", {7'h00, o_write_active}, {7'h00, en & w & (m != 2'h3)});
        check("rd", {7'h00, o_read_active}, {7'h00, en & !w & (m == 2'h1 || m == 2'h2)});
        cpu.stop();
        repeat (8) @(negedge i_ref_clk);
        check("pulse", 8'(pulses - p), {7'h00, en & w & (m == 2'h0)});
        check("data", o_wdata, e);
    endtask
    task automatic test_generic();
        run(2'h0, 1'b1, 1'b1, 8'hA5, 8'hA5);
        $display("test_generic done");
    endtask
    task automatic test_deselect();
        run(2'h0, 1'b0, 1'b1, 8'h5A, 8'hA5);
        $display("test_deselect done");
    endtask
    // spare bus code: pins ignored, nothing selected or captured
    task automatic test_none();
        run(2'h3, 1'b1, 1'b1, 8'h69, 8'hA5);
        $display("test_none done");
    endtask
    task automatic test_proc();
        run(2'h1, 1'b1, 1'b1, 8'h3C, 8'hA5);
        run(2'h1, 1'b1, 1'b0, 8'hC3, 8'hA5);
        run(2'h2, 1'b1, 1'b0, 8'h0F, 8'hA5);
        run(2'h2, 1'b1, 1'b1, 8'hF0, 8'hA5);
        $display("test_proc done");
    endtask
    // main sequence
    initial begin
        repeat (6) @(negedge i_ref_clk);
        i_reset = 0;
        repeat (4) @(negedge i_ref_clk);
        check("rst", o_wdata, 8'h00);
        test_generic();
        test_deselect();
        test_proc();
        test_none();
        conclude();
    end
endmodule
`default_nettype wire
